// file: bank_translator_pkg.sv
// constants shared by the bank translator and its helpers
`default_nettype none
package bank_translator_pkg;
  // ---------------------------------------------------------------
  // register map: printed offsets are indices, byte address = 4*index
  // ---------------------------------------------------------------
  localparam logic [9:0] WIN0_IDX = 10'h350; // window0_bank_select
  localparam logic [9:0] WIN1_IDX = 10'h351; // window1_bank_select
  localparam logic [9:0] WIN2_IDX = 10'h352; // window2_bank_select
  localparam logic [9:0] WIN3_IDX = 10'h353; // window3_bank_select
  localparam logic [7:0] BANK_REG_RESET = 8'h00; // all bank registers
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned EN_BIT = 7; // bank enable flag
  localparam int unsigned BANK_W_SMALL = 3; // windows 0..2 bank width
  localparam int unsigned BANK_W_WIDE = 5; // window 3 bank width
  // ---------------------------------------------------------------
  // fixed logical windows, compared against address bits 23..16
  // ---------------------------------------------------------------
  localparam logic [7:0] W0_LO = 8'h10;
  localparam logic [7:0] W0_HI = 8'h1F;
  localparam logic [7:0] W1_LO = 8'h40;
  localparam logic [7:0] W1_HI = 8'h5F;
  localparam logic [7:0] W2_LO = 8'hC0;
  localparam logic [7:0] W2_HI = 8'hDF;
  localparam logic [7:0] W3_LO = 8'h80;
  localparam logic [7:0] W3_HI = 8'hBF;
  // ---------------------------------------------------------------
  // idle levels of the select outputs
  // ---------------------------------------------------------------
  localparam logic [3:0] CS_IDLE = 4'hF;
  localparam logic [4:0] EXT_IDLE = 5'h1F;
  localparam int unsigned XLATE_LATENCY = 1; // cycles address in to pins
endpackage : bank_translator_pkg
`default_nettype wire

// file: bank_cfg_if.sv
// bank settings carried from the register file to the translator
`default_nettype none
interface bank_cfg_if;
  logic [3:0] en; // per-window bank enable
  logic [2:0] bank0; // window 0 bank, physical bits 22..20
  logic [2:0] bank1; // window 1 bank, physical bits 23..21
  logic [2:0] bank2; // window 2 bank, physical bits 23..21
  logic [4:0] bank3; // window 3 bank, low four bits to physical bits 25..22, bit 4 unused
  modport owner (output en, output bank0, output bank1, output bank2, output bank3);
  modport user (input en, input bank0, input bank1, input bank2, input bank3);
endinterface : bank_cfg_if
`default_nettype wire

// file: apb_bank_regs.sv
// apb slave holding the four window bank registers
`default_nettype none
module apb_bank_regs #(
  parameter int unsigned PADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  bank_cfg_if.owner cfg
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] en;
    logic [2:0] b0;
    logic [2:0] b1;
    logic [2:0] b2;
    logic [4:0] b3;
    logic [31:0] rdata;
  } regs_state_t;
  regs_state_t s_reg;
  regs_state_t s_next;
  // decode: bit 2 = hit, bits 1..0 = window
  function automatic logic [2:0] decode(input logic [PADDR_W-1:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    if (a[1:0] != 2'b00) decode = 3'b000;
    else if (idx == bank_translator_pkg::WIN0_IDX) decode = 3'b100;
    else if (idx == bank_translator_pkg::WIN1_IDX) decode = 3'b101;
    else if (idx == bank_translator_pkg::WIN2_IDX) decode = 3'b110;
    else if (idx == bank_translator_pkg::WIN3_IDX) decode = 3'b111;
    else decode = 3'b000;
  endfunction : decode
  logic [2:0] dec; // decoded current address
  // ---------------------------------------------------------------
  // next state: setup phase loads read data, access phase writes
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    dec = decode(paddr);
    if (psel && !penable && !pwrite) begin
      s_next.rdata = 32'h0000_0000; // reserved bits read as zero
      case (dec)
        3'b100: s_next.rdata[7:0] = {s_reg.en[0], 4'h0, s_reg.b0}; // RL2
        3'b101: s_next.rdata[7:0] = {s_reg.en[1], 4'h0, s_reg.b1}; // RL3
        3'b110: s_next.rdata[7:0] = {s_reg.en[2], 4'h0, s_reg.b2}; // RL4
        3'b111: s_next.rdata[7:0] = {s_reg.en[3], 2'b00, s_reg.b3}; // RL5
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite && pstrb[0] && dec[2]) begin
      s_next.en[dec[1:0]] = pwdata[bank_translator_pkg::EN_BIT];
      case (dec[1:0])
        2'd0: s_next.b0 = pwdata[2:0]; // RL2
        2'd1: s_next.b1 = pwdata[2:0]; // RL3
        2'd2: s_next.b2 = pwdata[2:0]; // RL4
        default: s_next.b3 = pwdata[4:0]; // RL5
      endcase
    end
  end
  // register update, all fields cleared at reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '0; // RL2 RL3 RL4 RL5
    end else begin
      s_reg <= s_next;
    end
  end
  // zero-wait slave; unmapped or misaligned access flags an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !dec[2];
  assign prdata = s_reg.rdata;
  assign cfg.en = s_reg.en;
  assign cfg.bank0 = s_reg.b0;
  assign cfg.bank1 = s_reg.b1;
  assign cfg.bank2 = s_reg.b2;
  assign cfg.bank3 = s_reg.b3;
endmodule : apb_bank_regs
`default_nettype wire

// file: ext_select_decoder.sv
// decodes extended chip selects from chip select two and window 3
`default_nettype none
module ext_select_decoder (
  input wire logic cs_two_n,
  input wire logic w3_banked,
  input wire logic [1:0] w3_group,
  output logic [4:0] ext_n
);
  // ---------------------------------------------------------------
  // one of five selects, only while chip select two is active
  // ---------------------------------------------------------------
  always_comb begin
    ext_n = bank_translator_pkg::EXT_IDLE;
    if (!cs_two_n) begin
      if (w3_banked) begin
        // bank code bits 3..2 pick second..fifth select
        ext_n[3'(w3_group) + 3'd1] = 1'b0; // RL5
      end else begin
        ext_n[0] = 1'b0; // program memory after reset RL14
      end
    end
  end
endmodule : ext_select_decoder
`default_nettype wire

// file: bank_translator.sv
// bank translator: logical to physical address with extended pins
// Function
// RL1: enabled window drives physical address from bank
// RL2: window0 register: enable bit7, bank bits2..0
// RL3: window1 register: enable bit7, bank bits2..0
// RL4: window2 register: enable bit7, bank bits2..0
// RL5: window3: 5-bit bank; codes 4..7 third select
// RL6: software never writes window3 codes 16..31
// RL7: top window3 bank bit has no effect
// RL8: window3 spans 80..BF, 4 MB banks
// RL9: window ranges are fixed, not programmable
// RL10: avoid bank overlapping the common area
// RL11: program banks only from common area
// RL12: below 16 MB, bank registers need no setup
// RL13: two upper address and extended select outputs
// RL14: after reset fetch comes from chip select two
// RL15: size chip selects to logical window size
// RL16: never rewrite bank register inside banked area
// RL17: disabled or outside window: address passes unchanged
`default_nettype none
module bank_translator #(
  parameter int unsigned PADDR_W = 12 // apb address width
) (
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side
  input wire logic [23:0] cpu_addr,
  input wire logic [3:0] cpu_cs_n,
  // memory side
  output logic [23:0] ext_addr,
  output logic upper_addr_out_24,
  output logic upper_addr_out_25,
  output logic chip_select_zero_n,
  output logic chip_select_one_n,
  output logic chip_select_two_n,
  output logic chip_select_three_n,
  output logic ext_select_first_n,
  output logic ext_select_second_n,
  output logic ext_select_third_n,
  output logic ext_select_fourth_n,
  output logic ext_select_fifth_n
);
  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (PADDR_W < 12) begin : g_bad_paddr
    $error("PADDR_W below 12 cannot reach the bank registers");
  end

  // ---------------------------------------------------------------
  // state: everything that reaches a pin is registered
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [23:0] addr; // low physical address
    logic up24; // physical bit 24
    logic up25; // physical bit 25
    logic [3:0] cs_n; // basic selects, delayed to match address
    logic [4:0] ext_n; // extended selects
  } pin_state_t;
  pin_state_t s_reg; // registered pin state
  pin_state_t s_next; // next pin state

  bank_cfg_if cfg (); // bank settings from the register file

  // window hit on address bits 23..16, bounds are constants
  function automatic logic in_win(
    input logic [7:0] ah, // address bits 23..16
    input logic [7:0] lo, // lowest byte inside
    input logic [7:0] hi // highest byte inside
  );
    in_win = (ah >= lo) && (ah <= hi);
  endfunction : in_win

  logic hit0; // logical address inside window 0
  logic hit1; // inside window 1
  logic hit2; // inside window 2
  logic hit3; // inside window 3
  logic [4:0] ext_dec; // decoder result
  logic w3_banked; // window 3 access with bank in use

  // ---------------------------------------------------------------
  // window detection, hard wired
  // ---------------------------------------------------------------
  // no register feeds these bounds, so software cannot move a window
  assign hit0 = in_win(cpu_addr[23:16],
    bank_translator_pkg::W0_LO, bank_translator_pkg::W0_HI); // RL9
  assign hit1 = in_win(cpu_addr[23:16],
    bank_translator_pkg::W1_LO, bank_translator_pkg::W1_HI); // RL9
  assign hit2 = in_win(cpu_addr[23:16],
    bank_translator_pkg::W2_LO, bank_translator_pkg::W2_HI); // RL9
  assign hit3 = in_win(cpu_addr[23:16],
    bank_translator_pkg::W3_LO, bank_translator_pkg::W3_HI); // RL8
  // window 3 translation and select decode only while its bank is in use
  assign w3_banked = hit3 && cfg.en[3];

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  // the slave holds the four bank registers and answers without wait
  apb_bank_regs #(
    .PADDR_W(PADDR_W)
  ) u_regs (
    .clk_sys(clk_sys),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg)
  );

  // ---------------------------------------------------------------
  // extended chip select decode
  // ---------------------------------------------------------------
  // decode sees the bank code as it stands in this cycle
  ext_select_decoder u_ext (
    .cs_two_n(cpu_cs_n[2]),
    .w3_banked(w3_banked),
    .w3_group(cfg.bank3[3:2]),
    .ext_n(ext_dec)
  );

  // ---------------------------------------------------------------
  // translation
  // ---------------------------------------------------------------
  // pass-through by default; a banked window overwrites its top bits
  always_comb begin
    s_next = s_reg;
    s_next.addr = cpu_addr; // RL17
    s_next.up24 = 1'b0; // RL17
    s_next.up25 = 1'b0; // RL17
    s_next.cs_n = cpu_cs_n; // basic selects pass through the same stage
    s_next.ext_n = ext_dec; // RL13
    if (hit0 && cfg.en[0]) begin
      // 1 MB banks: bank drives bits 22..20, bit 23 forced low
      s_next.addr[23:20] = {1'b0, cfg.bank0}; // RL1
    end else if (hit1 && cfg.en[1]) begin
      // 2 MB banks: bank drives bits 23..21
      s_next.addr[23:21] = cfg.bank1; // RL1
    end else if (hit2 && cfg.en[2]) begin
      // 2 MB banks: bank drives bits 23..21
      s_next.addr[23:21] = cfg.bank2; // RL1
    end else if (w3_banked) begin
      // 4 MB banks: bits 25..22; bank bit 4 has no pin to reach
      s_next.addr[23:22] = cfg.bank3[1:0]; // RL8
      s_next.up24 = cfg.bank3[2]; // RL13
      s_next.up25 = cfg.bank3[3]; // RL7
    end else begin
      // disabled window or common area: unchanged address
      s_next.addr = cpu_addr; // RL17
    end
  end

  // one register stage keeps address and selects aligned at the pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // pins idle: selects high, upper address low
      s_reg.addr <= 24'h00_0000;
      s_reg.up24 <= 1'b0;
      s_reg.up25 <= 1'b0;
      s_reg.cs_n <= bank_translator_pkg::CS_IDLE;
      s_reg.ext_n <= bank_translator_pkg::EXT_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  // address lines and the two upper pins
  assign ext_addr = s_reg.addr;
  assign upper_addr_out_24 = s_reg.up24;
  assign upper_addr_out_25 = s_reg.up25;
  // basic selects, one cycle behind the cpu
  assign chip_select_zero_n = s_reg.cs_n[0];
  assign chip_select_one_n = s_reg.cs_n[1];
  assign chip_select_two_n = s_reg.cs_n[2];
  assign chip_select_three_n = s_reg.cs_n[3];
  // extended selects
  assign ext_select_first_n = s_reg.ext_n[0];
  assign ext_select_second_n = s_reg.ext_n[1];
  assign ext_select_third_n = s_reg.ext_n[2];
  assign ext_select_fourth_n = s_reg.ext_n[3];
  assign ext_select_fifth_n = s_reg.ext_n[4];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // every check runs on the system clock; all but a_reg_reset rest during reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic [25:0] phys; // full physical address at the pins
  assign phys = {s_reg.up25, s_reg.up24, s_reg.addr};

  // window 0 maps bank into bits 22..20
  a_win0_map: assert property (hit0 && cfg.en[0] |=> // RL1
    phys == {3'b000, $past(cfg.bank0), $past(cpu_addr[19:0])})
    else $error("window 0 physical address wrong");

  // window 1 maps bank into bits 23..21
  a_win1_map: assert property (hit1 && cfg.en[1] |=> // RL3
    phys == {2'b00, $past(cfg.bank1), $past(cpu_addr[20:0])})
    else $error("window 1 physical address wrong");

  // window 2 maps bank into bits 23..21
  a_win2_map: assert property (hit2 && cfg.en[2] |=> // RL4
    phys == {2'b00, $past(cfg.bank2), $past(cpu_addr[20:0])})
    else $error("window 2 physical address wrong");

  // window 3 maps four low bank bits into bits 25..22
  a_win3_map: assert property (w3_banked |=> // RL8
    phys == {$past(cfg.bank3[3:0]), $past(cpu_addr[21:0])})
    else $error("window 3 physical address wrong");

  // flipping only bank bit 4 leaves the address the same
  a_top_bit_dead: assert property (w3_banked && $stable(cpu_addr) && $stable(cfg.bank3[3:0])
    && $changed(cfg.bank3[4]) |=> $stable(phys)) // RL7
    else $error("bank bit 4 changed the address");

  // disabled or unbanked access passes unchanged with upper pins low
  a_pass_through: assert property (!(hit0 && cfg.en[0]) && !(hit1 && cfg.en[1])
    && !(hit2 && cfg.en[2]) && !w3_banked |=> phys == {2'b00, $past(cpu_addr)}) // RL17
    else $error("pass-through address altered");

  // upper pins only rise for a banked window 3 access
  a_upper_low: assert property (!w3_banked |=> !upper_addr_out_24 && !upper_addr_out_25) // RL13
    else $error("upper address pin high outside window 3");

  // bank codes 4..7 give the third extended select alone
  a_third_select: assert property (w3_banked && !cpu_cs_n[2] && cfg.bank3[3:2] == 2'b01 |=>
    !ext_select_third_n && ext_select_second_n && ext_select_first_n) // RL5
    else $error("third extended select not chosen");

  // chip select two outside window 3 gives the first extended select
  a_fetch_cs2: assert property (!cpu_cs_n[2] && !w3_banked |=> !ext_select_first_n
    && !chip_select_two_n) // RL14
    else $error("program fetch select missing");

  // a write lands in window 3 register after one edge
  a_w3_write: assert property (psel && penable && pwrite && pstrb[0]
    && paddr[11:0] == {bank_translator_pkg::WIN3_IDX, 2'b00} |=>
    cfg.en[3] == $past(pwdata[7]) && cfg.bank3 == $past(pwdata[4:0])) // RL5
    else $error("window 3 register write lost");

  // reset clears every bank setting
  a_reg_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
    rst |=> cfg.en == 4'h0 && cfg.bank0 == 3'h0 && cfg.bank3 == 5'h00) // RL2
    else $error("bank registers not cleared by reset");

  // read of window 0 returns enable and bank with zero reserved bits
  a_w0_read: assert property (psel && !penable && !pwrite
    && paddr[11:0] == {bank_translator_pkg::WIN0_IDX, 2'b00} |=>
    prdata == {24'h00_0000, $past(cfg.en[0]), 4'h0, $past(cfg.bank0)}) // RL2
    else $error("window 0 read data wrong");

  // basic selects reach the pins one cycle after the cpu drives them
  a_cs_delay: assert property (1'b1 |=> // RL13
    {chip_select_three_n, chip_select_two_n, chip_select_one_n, chip_select_zero_n} == $past(cpu_cs_n))
    else $error("basic chip select not passed through");

  // chip select two idle leaves every extended select high
  a_ext_idle: assert property (cpu_cs_n[2] |=> ext_select_first_n && ext_select_second_n // RL13
    && ext_select_third_n && ext_select_fourth_n && ext_select_fifth_n)
    else $error("extended select active without chip select two");

  // a write lands in window 0 register after one edge
  a_w0_write: assert property (psel && penable && pwrite && pstrb[0] // RL2
    && paddr[11:0] == {bank_translator_pkg::WIN0_IDX, 2'b00} |=>
    cfg.en[0] == $past(pwdata[7]) && cfg.bank0 == $past(pwdata[2:0]))
    else $error("window 0 register write lost");

  // a write with byte lane 0 off changes no bank setting
  a_strobe_off: assert property (psel && penable && pwrite && !pstrb[0] |=> // RL5
    $stable(cfg.en) && $stable(cfg.bank0) && $stable(cfg.bank3))
    else $error("bank setting changed without byte strobe");

  // a banked window 3 access drives exactly one of the upper four selects
  a_one_ext: assert property (w3_banked && !cpu_cs_n[2] |=> // RL5
    $countones({ext_select_fifth_n, ext_select_fourth_n, ext_select_third_n,
    ext_select_second_n, ext_select_first_n}) == 4 && ext_select_first_n)
    else $error("extended select decode not one-hot");

  // main scenarios
  c_win3_bank5: cover property (w3_banked && cfg.bank3 == 5'h05 ##1 upper_addr_out_24);
  c_win2_banked: cover property (hit2 && cfg.en[2] && cfg.bank2 != 3'h0);
  c_apb_write: cover property (psel && penable && pwrite && pready);
  c_unmapped: cover property (pslverr);
  c_win0_banked: cover property (hit0 && cfg.en[0] && cfg.bank0 != 3'h0);
endmodule : bank_translator
`default_nettype wire

// file: mem_far_side.sv
// far-side memory chips: decode the pins into a physical address and read data
`default_nettype none
module mem_far_side (
  input wire logic clk_sys,
  input wire logic [23:0] ext_addr,
  input wire logic upper_addr_out_24,
  input wire logic upper_addr_out_25,
  input wire logic [3:0] cs_n,
  input wire logic [4:0] ext_n,
  output logic [25:0] phys,
  output logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // address decode and data bus
  // -------------------------------------------------------------
  logic [15:0] idle_pat = 16'h1234; // moves every cycle while released
  // address as the chips see it: two upper pins above the 24 lines
  assign phys = {upper_addr_out_25, upper_addr_out_24, ext_addr};
  // no pull on the data bus, so a stale value must never look valid
  always_ff @(posedge clk_sys) begin
    idle_pat <= ~idle_pat + 16'h0001;
  end
  // selected chip returns an address-derived word
  always_comb begin
    if (&cs_n && &ext_n) begin
      rd_data = idle_pat;
    end else begin
      rd_data = phys[15:0] ^ {6'h00, phys[25:16]};
    end
  end
endmodule : mem_far_side
`default_nettype wire

// file: tb.sv
// self-checking bench for the bank translator
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF, cpu_cs_n = 4'hF, cs_q_n;
  logic pready, pslverr, up24, up25;
  logic [23:0] cpu_addr = 24'h000000, ext_addr;
  logic [4:0] ext_q_n; // bit 0 is the first extended select
  logic [25:0] phys;
  logic [15:0] mem_data;
  logic [7:0] shadow [4]; // expected register contents
  int num_errors = 0, comparisons = 0, cycles = 0;

  bank_translator DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr), .cpu_cs_n(cpu_cs_n),
    .ext_addr(ext_addr), .upper_addr_out_24(up24), .upper_addr_out_25(up25),
    .chip_select_zero_n(cs_q_n[0]), .chip_select_one_n(cs_q_n[1]),
    .chip_select_two_n(cs_q_n[2]), .chip_select_three_n(cs_q_n[3]),
    .ext_select_first_n(ext_q_n[0]), .ext_select_second_n(ext_q_n[1]),
    .ext_select_third_n(ext_q_n[2]), .ext_select_fourth_n(ext_q_n[3]),
    .ext_select_fifth_n(ext_q_n[4]));

  mem_far_side mem (.clk_sys(clk_sys), .ext_addr(ext_addr), .upper_addr_out_24(up24),
    .upper_addr_out_25(up25), .cs_n(cs_q_n), .ext_n(ext_q_n), .phys(phys), .rd_data(mem_data));

  // -------------------------------------------------------------
  // clock and hang guard
  // -------------------------------------------------------------
  always #2 clk_sys = ~clk_sys;
  // whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up;
    end
  end

  // -------------------------------------------------------------
  // checking and bus tasks
  // -------------------------------------------------------------
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_pin(input string what, input logic [25:0] exp, input logic [25:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_pin

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    // no own limit: only the cycle ceiling ends a hung wait
    while (pready !== 1'h1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // register index to byte address, reserved bits masked in the shadow
  task automatic reg_wr(input int idx, input logic [7:0] v);
    logic [31:0] rd;
    logic err;
    apb(1'h1, {bank_translator_pkg::WIN0_IDX + 10'(idx), 2'h0}, {24'h0, v}, 4'hF, rd, err);
    chk_reg("write error", 32'h0, {31'h0, err});
    shadow[idx] = v & (idx == 3 ? 8'h9F : 8'h87);
  endtask : reg_wr

  task automatic reg_rd(input int idx);
    logic [31:0] rd;
    logic err;
    apb(1'h0, {bank_translator_pkg::WIN0_IDX + 10'(idx), 2'h0}, 32'h0, 4'hF, rd, err);
    chk_reg("register", {24'h0, shadow[idx]}, rd);
    chk_reg("read error", 32'h0, {31'h0, err});
  endtask : reg_rd

  // -------------------------------------------------------------
  // expected translation
  // -------------------------------------------------------------
  function automatic logic [25:0] exp_phys(input logic [23:0] a);
    logic [7:0] h;
    h = a[23:16];
    if (h >= 8'h10 && h <= 8'h1F && shadow[0][7]) return {3'h0, shadow[0][2:0], a[19:0]};
    if (h >= 8'h40 && h <= 8'h5F && shadow[1][7]) return {2'h0, shadow[1][2:0], a[20:0]};
    if (h >= 8'hC0 && h <= 8'hDF && shadow[2][7]) return {2'h0, shadow[2][2:0], a[20:0]};
    if (h >= 8'h80 && h <= 8'hBF && shadow[3][7]) return {shadow[3][3:0], a[21:0]};
    return {2'h0, a};
  endfunction : exp_phys

  // extended selects only qualify chip select two
  function automatic logic [4:0] exp_ext(input logic [23:0] a, input logic [3:0] csn);
    logic [2:0] k;
    k = (a[23:22] == 2'h2 && shadow[3][7]) ? 3'(shadow[3][3:2]) + 3'h1 : 3'h0;
    return csn[2] ? 5'h1F : ~(5'h01 << k);
  endfunction : exp_ext

  // present an address, check the pins one cycle later
  task automatic xl(input logic [23:0] a, input logic [3:0] csn);
    logic [25:0] p;
    p = exp_phys(a);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_cs_n <= csn;
    @(posedge clk_sys);
    #1;
    chk_pin("physical address", exp_phys(a), phys);
    chk_pin("selects", {17'h0, csn, exp_ext(a, csn)}, {17'h0, cs_q_n, ext_q_n});
    // a selected chip answers with a word derived from its own address
    if (csn != 4'hF) chk_pin("memory data", {10'h0, p[15:0] ^ {6'h0, p[25:16]}}, {10'h0, mem_data});
  endtask : xl

  // -------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic err;
    logic [23:0] probe [10];
    probe = '{24'h1ABCDE, 24'h0FFFFF, 24'h100000, 24'h5FFFFF, 24'h600000,
              24'h3FFFFF, 24'hC12345, 24'hDFFFFF, 24'hE00000, 24'h7FFFFF};
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++) reg_rd(i);
    xl(24'h812345, 4'hB);
    xl(24'h1ABCDE, 4'hE);
    // all reserved bits set: they must drop
    // banks are set while a window 0 access holds chip select zero; windows 1 and 2 land on common areas
    reg_wr(0, 8'hFD);
    reg_wr(1, 8'hFF);
    reg_wr(2, 8'hFB);
    reg_wr(3, 8'hE5);
    for (int i = 0; i < 4; i++) reg_rd(i);
    // window edges, inside and just outside
    for (int i = 0; i < 10; i++) xl(probe[i], 4'(i) ^ 4'h5);
    // all legal window-3 codes; prohibited codes are never written
    for (int c = 0; c < 16; c++) begin
      reg_wr(3, 8'h80 | 8'(c));
      xl(24'h800000 | 24'(c * 24'h01357), 4'hB);
      xl(24'hBFFFFF, 4'hF);
    end
    // enable clear: address passes through
    reg_wr(3, 8'h0F);
    xl(24'h9ABCDE, 4'hB);
    reg_wr(1, 8'h07);
    xl(24'h412345, 4'hD);
    // refused accesses leave registers alone
    apb(1'h1, 12'hD50, 32'hFF, 4'hF, rd, err);
    chk_reg("unmapped write error", 32'h1, {31'h0, err});
    apb(1'h0, 12'hD50, 32'h0, 4'hF, rd, err);
    chk_reg("unmapped read data", 32'h0, rd);
    chk_reg("unmapped read error", 32'h1, {31'h0, err});
    apb(1'h1, 12'hD41, 32'h00, 4'hF, rd, err);
    chk_reg("misaligned error", 32'h1, {31'h0, err});
    apb(1'h1, 12'hD40, 32'h00, 4'h0, rd, err);
    reg_rd(0);
    // reset in mid-run clears every bank setting
    rst <= 1'h1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    for (int i = 0; i < 4; i++) reg_rd(i);
    xl(24'hC00000, 4'hB);
    wrap_up;
  end
endmodule : tb
`default_nettype wire
